//--- hdl/dmec_top.v
// Device monitor enable control register with idle timers and trap gating
`timescale 1ns/1ps
`include "dmec_map.vh"

module dmec_top #(
    parameter TMR_W       = 16,
    parameter IDLE_RELOAD = 16'h00ff
) (
    // Clock, reset, enable
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        clk_en,
    // I/O register port
    input  wire [7:0]  io_addr,
    input  wire        io_wr,
    input  wire        io_rd,
    input  wire [31:0] io_wdata,
    output reg  [31:0] io_rdata,
    // Monitor events
    input  wire [13:0] trap_hit,
    input  wire [11:0] reload_evt,
    input  wire        bus_hold_request_n,
    input  wire [3:0]  bus_request_inputs,
    input  wire        timer_freeze,
    // Interrupt
    output reg         sys_mgmt_interrupt_n
);

    // ==========================================================================
    // Counter constants, sized to the timer so no bits are dropped
    localparam [TMR_W-1:0] TMR_ZERO = {TMR_W{1'b0}};
    localparam [TMR_W-1:0] TMR_ONE  = {{(TMR_W-1){1'b0}}, 1'b1};

    // ==========================================================================
    // Behaviour notes
    // - Trap hits and reload events are levels sampled each enabled clock.
    // - A trap hit held high keeps the interrupt low for as long as it stands.
    // - All twelve timers share one reload count; per-monitor counts are left out
    //   to keep the block small, software sees only the expiry status.
    // - Reload has priority over freeze, so a reload during freeze still loads.
    // - An expiry in the same cycle as a write-one clear leaves the bit set,
    //   so software never loses an event it has not seen.
    // - Clock enable low freezes every flop, outputs included.
    // - Timer freeze arrives as a pin from the global control logic.
    // - Bits 31 to 28 of control are never stored and read back zero.

    // ==========================================================================
    // Registers and their next values
    reg  [31:0]       device_monitor_control_r;
    reg  [31:0]       device_monitor_control_nxt;
    reg  [11:0]       idle_expired_status_r;
    reg  [11:0]       idle_expired_status_nxt;
    reg               intr_n_nxt;
    reg  [31:0]       io_rdata_nxt;

    // ==========================================================================
    // Decode and event wires
    // Timer and trap vectors
    wire [11:0]       expire;
    wire [11:0]       reload_go;
    wire [13:0]       trap_en;
    wire [13:0]       trap_fire;

    // Bus decode
    wire              ctrl_sel;
    wire              sts_sel;
    wire              ctrl_wr;
    wire              sts_wr;

    // Event helpers
    wire              bm_req;
    wire [11:0]       sts_clr;

    // Address decode; only two offsets answer, everything else reads zero
    assign ctrl_sel = (io_addr == `DMEC_OFS_CONTROL);
    assign sts_sel  = (io_addr == `DMEC_OFS_STATUS);
    assign ctrl_wr  = io_wr & ctrl_sel;
    assign sts_wr   = io_wr & sts_sel;

    // Any bus-master request: the hold request is active low, the others active high
    assign bm_req = ~bus_hold_request_n | (|bus_request_inputs);

    // Write-one-to-clear mask, only the twelve status bits matter
    assign sts_clr = sts_wr ? io_wdata[`DMEC_STS_MSB:0] : `DMEC_STS_RESET;

    // Trap enables for the two monitors without idle timers
    assign trap_en[`DMEC_MON_TRAP12] = device_monitor_control_r[`DMEC_BIT_TRAP12];
    assign trap_en[`DMEC_MON_TRAP13] = device_monitor_control_r[`DMEC_BIT_TRAP13];

    // A trap only fires where its enable is set
    assign trap_fire = trap_hit & trap_en;

    // ==========================================================================
    // Per-monitor idle timers
    // One loop builds the field decode, reload gating and down-counter of each
    genvar n;
    generate
        for (n = 0; n < 12; n = n + 1) begin : g_mon
            // Timer state and per-monitor helpers
            reg  [TMR_W-1:0] cnt_r;
            reg  [TMR_W-1:0] cnt_nxt;
            wire             idle_en;
            wire             base_ld;
            wire             at_one;

            // Each monitor owns a pair of bits: reload enable low, trap enable high
            assign idle_en    = device_monitor_control_r[`DMEC_FIELD_STRIDE*n+`DMEC_IDLE_OFS];
            assign trap_en[n] = device_monitor_control_r[`DMEC_FIELD_STRIDE*n+`DMEC_TRAP_OFS];

            // Monitor 3 needs the extra gate so it can serve as a pure software timer
            if (n == `DMEC_MON_GATE) begin : g_gate
                assign base_ld = reload_evt[n] & idle_en & device_monitor_control_r[`DMEC_BIT_GATE3];
            end else begin : g_plain
                assign base_ld = reload_evt[n] & idle_en;
            end

            // Monitor 8 also reloads on bus-master traffic when allowed
            if (n == `DMEC_MON_BM) begin : g_bm
                assign reload_go[n] = base_ld | (bm_req & device_monitor_control_r[`DMEC_BIT_BM8]);
            end else begin : g_nobm
                assign reload_go[n] = base_ld;
            end

            // Expiry is the step from one to zero, so an idle (zero) timer never fires
            assign at_one    = (cnt_r == TMR_ONE);
            assign expire[n] = at_one & ~reload_go[n] & ~timer_freeze;

            // Reload wins over counting; freeze holds the value
            always @* begin
                cnt_nxt = cnt_r;
                if (reload_go[n]) begin
                    cnt_nxt = IDLE_RELOAD[TMR_W-1:0];
                end else if (!timer_freeze && cnt_r != TMR_ZERO) begin
                    cnt_nxt = cnt_r - TMR_ONE;
                end
            end

            // Timer flops, frozen with the clock enable
            always @(posedge clk_sys) begin
                if (rst) begin
                    cnt_r <= TMR_ZERO;
                end else if (clk_en) begin
                    cnt_r <= cnt_nxt;
                end
            end
        end
    endgenerate

    // ==========================================================================
    // Control register: a plain read/write word, reserved bits never stored
    always @* begin
        device_monitor_control_nxt = device_monitor_control_r;
        if (ctrl_wr) begin
            device_monitor_control_nxt = io_wdata & `DMEC_CTRL_MASK;
        end
    end

    // Control flops; reset leaves every trap and reload disabled
    always @(posedge clk_sys) begin
        if (rst) begin
            device_monitor_control_r <= `DMEC_CTRL_RESET;
        end else if (clk_en) begin
            device_monitor_control_r <= device_monitor_control_nxt;
        end
    end

    // ==========================================================================
    // Idle status: hardware set beats a write-one clear in the same cycle
    always @* begin
        idle_expired_status_nxt = (idle_expired_status_r & ~sts_clr) | expire;
    end

    // Status flops
    always @(posedge clk_sys) begin
        if (rst) begin
            idle_expired_status_r <= `DMEC_STS_RESET;
        end else if (clk_en) begin
            idle_expired_status_r <= idle_expired_status_nxt;
        end
    end

    // ==========================================================================
    // Interrupt: low the cycle after any enabled trap hit or timer expiry
    always @* begin
        intr_n_nxt = ~((|trap_fire) | (|expire));
    end

    // Interrupt flop, idle high
    always @(posedge clk_sys) begin
        if (rst) begin
            sys_mgmt_interrupt_n <= 1'b1;
        end else if (clk_en) begin
            sys_mgmt_interrupt_n <= intr_n_nxt;
        end
    end

    // ==========================================================================
    // Read data: picked at the strobe, held until the next read
    // Unmapped offsets read zero
    always @* begin
        io_rdata_nxt = io_rdata;
        if (io_rd) begin
            if (ctrl_sel) begin
                io_rdata_nxt = device_monitor_control_r & `DMEC_CTRL_MASK;
            end else if (sts_sel) begin
                io_rdata_nxt = {`DMEC_STS_PAD, idle_expired_status_r};
            end else begin
                io_rdata_nxt = `DMEC_RDATA_IDLE;
            end
        end
    end

    // Read data flops
    always @(posedge clk_sys) begin
        if (rst) begin
            io_rdata <= `DMEC_RDATA_IDLE;
        end else if (clk_en) begin
            io_rdata <= io_rdata_nxt;
        end
    end

endmodule

//--- hdl/dmec_map.vh
// Register map and field constants for the device monitor enable control block
`ifndef DMEC_MAP_VH
`define DMEC_MAP_VH

// ==========================================================================
// Offsets
`define DMEC_OFS_CONTROL     8'h2c
`define DMEC_OFS_STATUS      8'h1c

// ==========================================================================
// Fields
`define DMEC_BIT_TRAP12      24
`define DMEC_BIT_TRAP13      25
`define DMEC_MON_TRAP12      12
`define DMEC_MON_TRAP13      13
`define DMEC_FIELD_STRIDE    2
`define DMEC_IDLE_OFS        0
`define DMEC_TRAP_OFS        1
`define DMEC_STS_MSB         11
`define DMEC_STS_RESET       12'h000
`define DMEC_STS_PAD         20'h00000
`define DMEC_RDATA_IDLE      32'h00000000
`define DMEC_BIT_GATE3       26
`define DMEC_BIT_BM8         27
`define DMEC_CTRL_MASK       32'h0fffffff
`define DMEC_STS_MASK        32'h00000fff
`define DMEC_CTRL_RESET      32'h00000000
`define DMEC_MON_GATE        3
`define DMEC_MON_BM          8

`endif

//--- sim/dmec_asserts.sv
// Checker for the device monitor enable control block
`timescale 1ns/1ps
module dmec_chk (
    // Port signals
    input logic        clk_sys,
    input logic        rst,
    input logic        clk_en,
    input logic [7:0]  io_addr,
    input logic        io_wr,
    input logic        io_rd,
    input logic [31:0] io_wdata,
    input logic [31:0] io_rdata,
    input logic [13:0] trap_hit,
    input logic        sys_mgmt_interrupt_n
);
    // Shadow of control; a read in the same cycle as a write is judged against the written value
    logic [31:0] c_r;
    wire wc = clk_en && io_wr && io_addr == 8'h2c;
    wire rc = clk_en && io_rd && io_addr == 8'h2c;
    wire rs = clk_en && io_rd && io_addr == 8'h1c;
    wire [13:0] te = {c_r[25:23], c_r[21], c_r[19], c_r[17], c_r[15], c_r[13], c_r[11], c_r[9], c_r[7], c_r[5], c_r[3], c_r[1]};
    always @(posedge clk_sys) c_r <= rst ? 32'h0 : wc ? io_wdata & 32'h0fffffff : c_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ==========================================
    // Properties
    property p_trap; clk_en && |(trap_hit & te) |=> !sys_mgmt_interrupt_n; endproperty
    a_trap: assert property (p_trap) else $error("trap lost");
    property p_rd; rc |=> io_rdata == c_r; endproperty
    a_rd: assert property (p_rd) else $error("control readback");
    property p_wr; wc ##1 rc |=> io_rdata == ($past(io_wdata, 2) & 32'h0fffffff); endproperty
    a_wr: assert property (p_wr) else $error("reserved bits");
    property p_sts; rs |=> io_rdata[31:12] == 20'h0; endproperty
    a_sts: assert property (p_sts) else $error("status width");
    property p_unm; clk_en && io_rd && io_addr != 8'h2c && io_addr != 8'h1c |=> io_rdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_hold; !(clk_en && io_rd) |=> $stable(io_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_frz; !clk_en |=> $stable(sys_mgmt_interrupt_n); endproperty
    a_frz: assert property (p_frz) else $error("interrupt moved");
    property p_rst; disable iff (1'b0) rst |=> io_rdata == 32'h0 && sys_mgmt_interrupt_n; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind dmec_top dmec_chk u_chk (.*);

//--- sim/dmec_top_test.sv
// Self-checking testbench for the device monitor enable control block
`timescale 1ns/1ps
module dmec_top_test;
    logic clk_sys = 0, rst = 1, clk_en = 1, io_wr = 0, io_rd = 0, bus_hold_request_n = 1, timer_freeze = 0;
    logic [7:0] io_addr = 0;
    logic [31:0] io_wdata = 0;
    wire [31:0] io_rdata;
    wire sys_mgmt_interrupt_n;
    logic [13:0] trap_hit = 0;
    logic [11:0] reload_evt = 0;
    logic [3:0] bus_request_inputs = 0;
    integer miscompares = 0, checks_done = 0, i;
    // Rows: control, events, {hold, requests}, expected status
    logic [60:0] rows [8] = '{{32'hf0000001, 12'h001, 5'h00, 12'h001}, {32'h0, 12'hfff, 5'h00, 12'h000},
        {32'h00000040, 12'h008, 5'h00, 12'h000}, {32'h04000040, 12'h008, 5'h00, 12'h008},
        {32'h08010000, 12'h000, 5'h08, 12'h100}, {32'h08010000, 12'h000, 5'h10, 12'h100},
        {32'h00010000, 12'h000, 5'h1f, 12'h000}, {32'h00555555, 12'hfff, 5'h00, 12'hff7}};
    always #10 clk_sys = ~clk_sys;
    dmec_top #(.IDLE_RELOAD(16'h0004)) dut (.*);
    task chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Bus tasks start and end on a falling edge, so accesses run back to back
    task wr(input [7:0] a, input [31:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1;
        @(negedge clk_sys) io_wr = 0;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        io_addr = a;
        io_rd = 1;
        @(negedge clk_sys) io_rd = 0;
        chk(io_rdata, e);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog, far beyond the roughly 160 cycles the run needs
    initial begin
        #100000;
        miscompares++;
        tally_and_finish;
    end
    initial begin
        repeat (4) @(negedge clk_sys);
        rst = 0;
        rd(8'h2c, 0);
        for (i = 0; i < 8; i++) begin
            wr(8'h2c, rows[i][60:29]);
            rd(8'h2c, rows[i][60:29] & 32'h0fffffff);
            reload_evt = rows[i][28:17];
            bus_hold_request_n = !rows[i][16];
            bus_request_inputs = rows[i][15:12];
            @(negedge clk_sys) reload_evt = 0;
            bus_hold_request_n = 1;
            bus_request_inputs = 0;
            repeat (10) @(negedge clk_sys);
            rd(8'h1c, rows[i][11:0]);
            wr(8'h1c, 32'hfff);
            $display("row %0d done", i);
        end
        // Traps on monitors 13 and 0, then disabled ones, then with clock enable low
        wr(8'h2c, 32'h02000002);
        trap_hit = 14'h2000;
        @(negedge clk_sys) trap_hit = 14'h0001;
        chk(sys_mgmt_interrupt_n, 0);
        @(negedge clk_sys) trap_hit = 14'h1ffe;
        chk(sys_mgmt_interrupt_n, 0);
        @(negedge clk_sys) clk_en = 0;
        chk(sys_mgmt_interrupt_n, 1);
        trap_hit = 14'h0001;
        @(negedge clk_sys) clk_en = 1;
        trap_hit = 0;
        chk(sys_mgmt_interrupt_n, 1);
        $display("trap test done");
        // Freeze holds a loaded timer until released
        wr(8'h2c, 32'h1);
        timer_freeze = 1;
        reload_evt = 1;
        @(negedge clk_sys) reload_evt = 0;
        repeat (10) @(negedge clk_sys);
        rd(8'h1c, 0);
        timer_freeze = 0;
        repeat (3) @(negedge clk_sys);
        chk(sys_mgmt_interrupt_n, 1);
        @(negedge clk_sys);
        chk(sys_mgmt_interrupt_n, 0);
        @(negedge clk_sys);
        chk(sys_mgmt_interrupt_n, 1);
        repeat (5) @(negedge clk_sys);
        rd(8'h1c, 1);
        rd(8'h30, 0);
        rst = 1;
        @(negedge clk_sys) rst = 0;
        rd(8'h2c, 0);
        rd(8'h1c, 0);
        $display("freeze and reset test done");
        tally_and_finish;
    end
endmodule
